/* design/dual_timer.sv */
// two 8-bit timer channels with cascade, carrier and pwm modes
//
// Functional notes
// - discrete: two 8-bit interval timers; only b gives a square wave
// - cascade: channels form one 16-bit interval timer and square wave source
// - carrier: b's carrier is gated onto the pin in bursts timed by a
// - pwm on channel b: duty set by b's low and high width registers
// - channel a compares count with its compare, pulses a irq on equality
// - channel b compares count with low-width compare, pulses b irq on match
// - cascade: b irq only on both matching together, a irq never
// - carrier and pwm: low-width compare sets pin low time
// - carrier and pwm: high-width compare sets pin high time
// - carrier and pwm: channel b also compares against high-width compare, pulses b irq
// - both counters readable and zero after reset
// - compare registers have no reset value; load before starting
// - discrete: counter clears on run low, own match, or overflow
// - cascade: both clear on b run low, joint match, joint overflow
// - carrier and pwm: b clears on run low, width match, overflow; a as in discrete
// - modes 000 discrete, 101 cascade, 011 carrier, 010 pwm; rest barred
// - cascade: b's run bit starts and stops both, a's run bit ignored
// - cascade: a's count clock forced to b's overflow signal
`timescale 1ns/100ps
`default_nettype none
module dual_timer (
    input  wire logic        sys_clk,          // 100 MHz system clock
    input  wire logic        rstn,             // async reset, active low
    input  wire logic [15:0] cpu_addr,         // register byte address
    input  wire logic        cpu_wr,           // write strobe, one cycle
    input  wire logic        cpu_rd,           // read strobe, one cycle
    input  wire logic [7:0]  cpu_wdata,        // write data
    output logic      [7:0]  cpu_rdata,        // read data, cycle after rd
    output logic             chan_a_match_irq, // channel a match pulse
    output logic             chan_b_match_irq, // channel b match pulse
    output logic             timer_out_pin,    // timer output level
    output logic             timer_out_en      // pin driven as timer output
);
    // register file
    tmr_pkg::mode_ctrl_a_t chan_a_mode_ctrl_q;
    tmr_pkg::mode_ctrl_b_t chan_b_mode_ctrl_q;
    logic [7:0]            chan_a_compare_q;
    logic [7:0]            chan_b_low_compare_q;
    logic [7:0]            chan_b_high_compare_q;
    logic [7:0]            chan_a_counter;
    logic [7:0]            chan_b_counter;
    logic [7:0]            rdata_d;
    logic [7:0]            rdata_q;

    // address decode
    wire sel_mode_a = cpu_addr == tmr_pkg::ADDR_MODE_A;
    wire sel_mode_b = cpu_addr == tmr_pkg::ADDR_MODE_B;
    wire sel_cnt_a  = cpu_addr == tmr_pkg::ADDR_CNT_A;
    wire sel_cnt_b  = cpu_addr == tmr_pkg::ADDR_CNT_B;
    wire sel_cmp_a  = cpu_addr == tmr_pkg::ADDR_CMP_A;
    wire sel_cmp_bl = cpu_addr == tmr_pkg::ADDR_CMP_B_LO;
    wire sel_cmp_bh = cpu_addr == tmr_pkg::ADDR_CMP_B_HI;

    // reserved bits forced to zero on write
    wire [7:0] wmask_a = 8'h9a;
    wire [7:0] wmask_b = 8'hbf;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            chan_a_mode_ctrl_q <= tmr_pkg::MODE_CTRL_RST;
            chan_b_mode_ctrl_q <= tmr_pkg::MODE_CTRL_RST;
        end else if (cpu_wr) begin
            if (sel_mode_a) begin
                chan_a_mode_ctrl_q <= cpu_wdata & wmask_a;
            end
            if (sel_mode_b) begin
                chan_b_mode_ctrl_q <= cpu_wdata & wmask_b;
            end
        end
    end

    // compare registers deliberately carry no reset
    always_ff @(posedge sys_clk) begin
        if (cpu_wr && sel_cmp_a) begin
            chan_a_compare_q <= cpu_wdata;
        end
        if (cpu_wr && sel_cmp_bl) begin
            chan_b_low_compare_q <= cpu_wdata;
        end
        if (cpu_wr && sel_cmp_bh) begin
            chan_b_high_compare_q <= cpu_wdata;
        end
    end

    // read mux, unmapped addresses read zero; counters live
    assign rdata_d = sel_mode_a ? 8'(chan_a_mode_ctrl_q) :
                     sel_mode_b ? 8'(chan_b_mode_ctrl_q) :
                     sel_cnt_a  ? chan_a_counter :
                     sel_cnt_b  ? chan_b_counter :
                     sel_cmp_a  ? chan_a_compare_q :
                     sel_cmp_bl ? chan_b_low_compare_q :
                     sel_cmp_bh ? chan_b_high_compare_q :
                                  tmr_pkg::RDATA_RST;

    // read data held between reads so a slow master can take it late
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= tmr_pkg::RDATA_RST;
        end else if (cpu_rd) begin
            rdata_q <= rdata_d;
        end
    end
    assign cpu_rdata = rdata_q;

    // mode decode
    // barred codes fail m_legal and hold both counters at zero
    wire [2:0] mode_code = {chan_a_mode_ctrl_q.mode_sel_a,
                            chan_b_mode_ctrl_q.mode_sel_b_hi,
                            chan_b_mode_ctrl_q.mode_sel_b_lo};
    wire m_disc  = mode_code == tmr_pkg::MODE_DISCRETE;
    wire m_casc  = mode_code == tmr_pkg::MODE_CASCADE;
    wire m_carr  = mode_code == tmr_pkg::MODE_CARRIER;
    wire m_pwm   = mode_code == tmr_pkg::MODE_PWM;
    wire m_width = m_carr | m_pwm;
    wire m_legal = m_disc | m_casc | m_width;

    // b's run bit governs both in cascade; barred codes stop both
    wire run_b = m_legal & chan_b_mode_ctrl_q.run;
    wire run_a = m_casc ? chan_b_mode_ctrl_q.run :
                 (m_legal & chan_a_mode_ctrl_q.run);

    // count clocks
    logic [tmr_pkg::PRE_W:0] pre_tick;

    tmr_prescaler #(
        .W (tmr_pkg::PRE_W)
    ) u_pre (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .tick    (pre_tick)
    );

    // b clock codes 6 and 7 are barred and give no tick
    logic b_tick;
    always_comb begin
        unique case (chan_b_mode_ctrl_q.clk_sel)
            tmr_pkg::BCLK_DIV1:   b_tick = pre_tick[0];
            tmr_pkg::BCLK_DIV4_0: b_tick = pre_tick[2];
            tmr_pkg::BCLK_DIV2:   b_tick = pre_tick[1];
            tmr_pkg::BCLK_DIV4_1: b_tick = pre_tick[2];
            tmr_pkg::BCLK_DIV8:   b_tick = pre_tick[3];
            tmr_pkg::BCLK_DIV16:  b_tick = pre_tick[4];
            default:              b_tick = 1'b0;
        endcase
    end

    // compare logic
    tmr_pkg::phase_t phase_q;
    tmr_pkg::phase_t phase_d;

    wire a_eq  = chan_a_counter == chan_a_compare_q;
    wire bl_eq = chan_b_counter == chan_b_low_compare_q;
    wire bh_eq = chan_b_counter == chan_b_high_compare_q;

    // all-ones detects; b's feeds the cascade carry into a
    wire b_wrap = chan_b_counter == 8'hff;
    wire a_wrap = chan_a_counter == 8'hff;

    // width modes compare against the register of the running phase
    wire b_lo_hit = run_b & b_tick & bl_eq &
                    (!m_width | (phase_q == tmr_pkg::PH_LOW));
    wire b_hi_hit = run_b & b_tick & bh_eq & m_width &
                    (phase_q == tmr_pkg::PH_HIGH);
    wire b_match  = (b_lo_hit | b_hi_hit) & !m_casc;

    // cascade: 16-bit compare of {a,b} against {a,b} compares
    wire casc_hit = m_casc & run_b & b_tick & bl_eq & a_eq;
    // cascade carry, b's overflow signal feeding a
    wire b_carry  = m_casc & run_b & b_tick & b_wrap & !casc_hit;

    // b output toggle (discrete) or low-width match (width modes) event used as a clock source outside cascade
    wire b_out_evt = m_width ? b_lo_hit : b_match;

    // cascade overrides a's own clock select
    logic a_tick;
    always_comb begin
        if (m_casc) begin
            a_tick = b_carry;
        end else begin
            unique case (chan_a_mode_ctrl_q.clk_sel)
                tmr_pkg::ACLK_DIV64:   a_tick = pre_tick[tmr_pkg::TAP_A0];
                tmr_pkg::ACLK_DIV256:  a_tick = pre_tick[tmr_pkg::TAP_A1];
                tmr_pkg::ACLK_B_MATCH: a_tick = b_match;
                tmr_pkg::ACLK_B_OUT:   a_tick = b_out_evt;
            endcase
        end
    end

    // a's own compare is suppressed in cascade mode
    wire a_match = !m_casc & run_a & a_tick & a_eq;

    // counters
    // discrete: each clears on own match, wraps on overflow
    // cascade: joint match clears both, joint wrap is natural
    // width modes: b clears on either width match
    // cascade lets b run past its own low match until a agrees too
    wire b_clr = m_casc ? casc_hit :
                 (b_lo_hit | b_hi_hit);
    wire a_clr = m_casc ? casc_hit : a_match;

    tmr_counter #(
        .W (8)
    ) u_cnt_a (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (run_a),
        .inc     (a_tick),
        .clr     (a_clr),
        .cnt_q   (chan_a_counter)
    );

    tmr_counter #(
        .W (8)
    ) u_cnt_b (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (run_b),
        .inc     (b_tick),
        .clr     (b_clr),
        .cnt_q   (chan_b_counter)
    );

    // width phase; restarts low when b stops or leaves the width modes
    always_comb begin
        phase_d = phase_q;
        if (!run_b || !m_width) begin
            phase_d = tmr_pkg::PH_LOW;
        end else begin
            unique case (phase_q)
                tmr_pkg::PH_LOW: begin
                    if (b_lo_hit) begin
                        phase_d = tmr_pkg::PH_HIGH;
                    end
                end
                tmr_pkg::PH_HIGH: begin
                    if (b_hi_hit) begin
                        phase_d = tmr_pkg::PH_LOW;
                    end
                end
            endcase
        end
    end

    // output logic
    logic sq_q;
    logic sq_d;
    logic gate_q;
    logic gate_d;
    logic pin_d;

    // square wave toggles on b match (discrete) or joint match (cascade)
    wire sq_flip = (m_disc & b_match) | casc_hit;
    assign sq_d = !run_b  ? 1'b0 :
                  sq_flip ? !sq_q : sq_q;

    // carrier burst window flips on each channel a match
    wire gate_on = m_carr & run_a;
    assign gate_d = !gate_on ? 1'b0 :
                    a_match  ? !gate_q : gate_q;

    // barred mode codes leave the pin low
    always_comb begin
        pin_d = 1'b0;
        if (m_pwm) begin
            pin_d = phase_d == tmr_pkg::PH_HIGH;
        end else if (m_carr) begin
            pin_d = gate_d & (phase_d == tmr_pkg::PH_HIGH);
        end else if (m_disc || m_casc) begin
            pin_d = sq_d;
        end
    end

    // pin and enable share an edge; a disabled pin never shows high
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase_q          <= tmr_pkg::PH_LOW;
            sq_q             <= 1'b0;
            gate_q           <= 1'b0;
            timer_out_pin    <= 1'b0;
            timer_out_en     <= 1'b0;
            chan_a_match_irq <= 1'b0;
            chan_b_match_irq <= 1'b0;
        end else begin
            phase_q          <= phase_d;
            sq_q             <= sq_d;
            gate_q           <= gate_d;
            timer_out_pin    <= pin_d & chan_b_mode_ctrl_q.out_en;
            timer_out_en     <= chan_b_mode_ctrl_q.out_en;
            chan_a_match_irq <= a_match;
            chan_b_match_irq <= b_match | casc_hit;
        end
    end
endmodule
`default_nettype wire

/* inc/tmr_pkg.sv */
// shared constants and types for the dual 8-bit timer block
package tmr_pkg;

    // register byte addresses on the cpu bus
    localparam logic [15:0] ADDR_MODE_A    = 16'hff62;
    localparam logic [15:0] ADDR_MODE_B    = 16'hff69;
    localparam logic [15:0] ADDR_CNT_A     = 16'hff5c;
    localparam logic [15:0] ADDR_CNT_B     = 16'hff5d;
    localparam logic [15:0] ADDR_CMP_A     = 16'hff5e;
    localparam logic [15:0] ADDR_CMP_B_LO  = 16'hff5f;
    localparam logic [15:0] ADDR_CMP_B_HI  = 16'hff60;

    // reset values
    localparam logic [7:0] MODE_CTRL_RST   = 8'h00;
    localparam logic [7:0] CNT_RST         = 8'h00;
    localparam logic [7:0] RDATA_RST       = 8'h00;

    // prescaler taps (log2 of division)
    localparam int unsigned PRE_W          = 8;
    localparam int unsigned TAP_A0         = 6;
    localparam int unsigned TAP_A1         = 8;

    // channel b clock select codes
    localparam logic [2:0] BCLK_DIV1       = 3'h0;
    localparam logic [2:0] BCLK_DIV4_0     = 3'h1;
    localparam logic [2:0] BCLK_DIV2       = 3'h2;
    localparam logic [2:0] BCLK_DIV4_1     = 3'h3;
    localparam logic [2:0] BCLK_DIV8       = 3'h4;
    localparam logic [2:0] BCLK_DIV16      = 3'h5;

    // channel a clock select codes
    localparam logic [1:0] ACLK_DIV64      = 2'h0;
    localparam logic [1:0] ACLK_DIV256     = 2'h1;
    localparam logic [1:0] ACLK_B_MATCH    = 2'h2;
    localparam logic [1:0] ACLK_B_OUT      = 2'h3;

    // combined mode code {mode_sel_a, mode_sel_b_hi, mode_sel_b_lo}
    typedef enum logic [2:0] {
        MODE_DISCRETE = 3'b000,
        MODE_CASCADE  = 3'b101,
        MODE_CARRIER  = 3'b011,
        MODE_PWM      = 3'b010
    } tmr_mode_t;

    // output phase of the width generator
    typedef enum logic [0:0] {
        PH_LOW  = 1'b0,
        PH_HIGH = 1'b1
    } phase_t;

    // channel a mode control layout
    typedef struct packed {
        logic       run;
        logic [1:0] zero_65;
        logic [1:0] clk_sel;
        logic       zero_2;
        logic       mode_sel_a;
        logic       zero_0;
    } mode_ctrl_a_t;

    // channel b mode control layout
    typedef struct packed {
        logic       run;
        logic       zero_6;
        logic [2:0] clk_sel;
        logic       mode_sel_b_hi;
        logic       mode_sel_b_lo;
        logic       out_en;
    } mode_ctrl_b_t;

endpackage

/* design/tmr_prescaler.sv */
// free-running divider giving one-cycle enables at power-of-two rates
`timescale 1ns/100ps
`default_nettype none
module tmr_prescaler #(
    parameter int unsigned W = tmr_pkg::PRE_W
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rstn,    // async reset, active low
    output logic [W:0]        tick     // tick[k]: enable every 2**k cycles
);
    logic [W-1:0] div_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick[0] = 1'b1;
    for (genvar k = 1; k <= W; k++) begin : g_tap
        assign tick[k] = &div_q[k-1:0];
    end
endmodule
`default_nettype wire

/* design/tmr_counter.sv */
// 8-bit up counter with stop-clear, match-clear and natural wrap
`timescale 1ns/100ps
`default_nettype none
module tmr_counter #(
    parameter int unsigned W = 8
) (
    input  wire logic         sys_clk, // system clock
    input  wire logic         rstn,    // async reset, active low
    input  wire logic         run,     // low holds the count at zero
    input  wire logic         inc,     // count enable pulse
    input  wire logic         clr,     // clear pulse, wins over inc
    output logic [W-1:0]      cnt_q    // current count
);
    logic [W-1:0] cnt_d;

    assign cnt_d = !run ? '0 :
                   clr  ? '0 :
                   inc  ? W'(cnt_q + 1'b1) : cnt_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

/* dv/dual_timer_chk_properties.sv */
// port-level assertions for the dual timer
`timescale 1ns/100ps
`default_nettype none
module dual_timer_chk (
    input wire logic        sys_clk,          // clock
    input wire logic        rstn,             // reset, active low
    input wire logic [15:0] cpu_addr,         // address
    input wire logic        cpu_wr,           // write strobe
    input wire logic        cpu_rd,           // read strobe
    input wire logic [7:0]  cpu_wdata,        // write data
    input wire logic [7:0]  cpu_rdata,        // read data
    input wire logic        chan_a_match_irq, // a match pulse
    input wire logic        chan_b_match_irq, // b match pulse
    input wire logic        timer_out_pin,    // pin level
    input wire logic        timer_out_en      // pin enable
);
    logic [7:0] ma_q, mb_q, lo_q, hi_q;
    logic [8:0] gap_q;
    logic       valid_q;
    wire  [2:0] mode = {ma_q[1], mb_q[2], mb_q[1]};
    wire        casc = mode == tmr_pkg::MODE_CASCADE;
    wire        pwm  = mode == tmr_pkg::MODE_PWM;
    wire        disc = mode == tmr_pkg::MODE_DISCRETE;
    wire        a_off = casc ? !mb_q[7] : !ma_q[7];
    wire        w_ma = cpu_wr && cpu_addr == tmr_pkg::ADDR_MODE_A;
    wire        w_mb = cpu_wr && cpu_addr == tmr_pkg::ADDR_MODE_B;
    wire        w_lo = cpu_wr && cpu_addr == tmr_pkg::ADDR_CMP_B_LO;
    wire        w_hi = cpu_wr && cpu_addr == tmr_pkg::ADDR_CMP_B_HI;
    wire        r_a = cpu_rd && cpu_addr == tmr_pkg::ADDR_CNT_A;
    wire        r_b = cpu_rd && cpu_addr == tmr_pkg::ADDR_CNT_B;
    // shadow of the settings; gap counts cycles between b pulses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ma_q    <= 8'h00;
            mb_q    <= 8'h00;
            lo_q    <= 8'h00;
            hi_q    <= 8'h00;
            gap_q   <= 9'h001;
            valid_q <= 1'b0;
        end else begin
            ma_q    <= w_ma ? cpu_wdata : ma_q;
            mb_q    <= w_mb ? cpu_wdata : mb_q;
            lo_q    <= w_lo ? cpu_wdata : lo_q;
            hi_q    <= w_hi ? cpu_wdata : hi_q;
            gap_q   <= chan_b_match_irq ? 9'h001 : gap_q + 9'h001;
            valid_q <= !(cpu_wr || !mb_q[7]) && (valid_q || chan_b_match_irq);
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_en_follows: assert property (
        w_mb ##1 !w_mb |=> timer_out_en == $past(cpu_wdata[0], 2))
        else $error("output enable differs from written bit");
    chk_pin_gated: assert property (
        !timer_out_en |-> !timer_out_pin)
        else $error("pin high while output disabled");
    chk_b_stop_clear: assert property (
        r_b && !mb_q[7] && !$past(mb_q[7]) |=> cpu_rdata == 8'h00)
        else $error("b count not zero while stopped");
    chk_a_stop_clear: assert property (
        r_a && a_off && $past(a_off) && $stable(mode) |=> cpu_rdata == 8'h00)
        else $error("a count not zero while stopped");
    chk_casc_no_a: assert property (
        casc && $past(casc) |-> !chan_a_match_irq)
        else $error("a pulse in cascade mode");
    chk_pwm_toggle: assert property (
        pwm && mb_q[7] && mb_q[0] && $stable(mb_q) && $changed(timer_out_pin)
        |-> chan_b_match_irq)
        else $error("pwm pin moved without b pulse");
    chk_b_interval: assert property (
        chan_b_match_irq && valid_q && disc && mb_q[5:3] == 3'h0
        |-> gap_q == {1'b0, lo_q} + 9'h001)
        else $error("b interval wrong in discrete mode");
    chk_pwm_width: assert property (
        chan_b_match_irq && valid_q && pwm && mb_q[5:3] == 3'h0 && mb_q[0]
        |-> gap_q == (timer_out_pin ? {1'b0, lo_q} : {1'b0, hi_q}) + 9'h001)
        else $error("pwm phase width wrong");
    cov_pwm: cover property (pwm && chan_b_match_irq);
    cov_casc: cover property (casc && chan_b_match_irq);
    cov_a: cover property (disc && chan_a_match_irq);
endmodule
bind dual_timer dual_timer_chk i_chk (
    .sys_clk          (sys_clk),
    .rstn             (rstn),
    .cpu_addr         (cpu_addr),
    .cpu_wr           (cpu_wr),
    .cpu_rd           (cpu_rd),
    .cpu_wdata        (cpu_wdata),
    .cpu_rdata        (cpu_rdata),
    .chan_a_match_irq (chan_a_match_irq),
    .chan_b_match_irq (chan_b_match_irq),
    .timer_out_pin    (timer_out_pin),
    .timer_out_en     (timer_out_en)
);
`default_nettype wire

/* dv/pin_load.sv */
// external load on the timer output, measuring level widths
`timescale 1ns/100ps
`default_nettype none
module pin_load (
    input  wire logic sys_clk,       // clock
    input  wire logic rstn,          // reset, active low
    input  wire logic timer_out_pin, // pin level
    input  wire logic timer_out_en,  // pin driven
    output var  int   hi_w,          // last high width in cycles
    output var  int   lo_w           // last low width in cycles
);
    int   run_n;
    logic last_q;
    // load pulls the line low when undriven
    wire  lvl = timer_out_en & timer_out_pin;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            run_n  <= 1;
            hi_w   <= 0;
            lo_w   <= 0;
            last_q <= 1'b0;
        end else if (lvl !== last_q) begin
            if (last_q) hi_w <= run_n;
            else lo_w <= run_n;
            run_n  <= 1;
            last_q <= lvl;
        end else begin
            run_n  <= run_n + 1;
        end
    end
endmodule
`default_nettype wire

/* dv/dual_timer_tb_top.sv */
// self-checking bench for the dual timer
`timescale 1ns/100ps
`default_nettype none
module dual_timer_tb_top;
    logic        sys_clk, rstn, cpu_wr, cpu_rd, a_irq, b_irq, pin, pin_en;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata;
    int          num_errors = 0, checked = 0, cyc = 0, a_n = 0, b_n = 0;
    int          a_last = 0, b_last = 0, a_gap = 0, b_gap = 0, s_a, hi_w, lo_w;
    dual_timer i_dut (
        .sys_clk          (sys_clk),
        .rstn             (rstn),
        .cpu_addr         (cpu_addr),
        .cpu_wr           (cpu_wr),
        .cpu_rd           (cpu_rd),
        .cpu_wdata        (cpu_wdata),
        .cpu_rdata        (cpu_rdata),
        .chan_a_match_irq (a_irq),
        .chan_b_match_irq (b_irq),
        .timer_out_pin    (pin),
        .timer_out_en     (pin_en)
    );
    pin_load i_load (
        .sys_clk       (sys_clk),
        .rstn          (rstn),
        .timer_out_pin (pin),
        .timer_out_en  (pin_en),
        .hi_w          (hi_w),
        .lo_w          (lo_w)
    );
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // pulse counts and spacing of each match pulse
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (a_irq === 1'b1) begin
            a_gap = cyc - a_last;
            a_last = cyc;
            a_n++;
        end
        if (b_irq === 1'b1) begin
            b_gap = cyc - b_last;
            b_last = cyc;
            b_n++;
        end
    end
    task automatic final_report();
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        @(negedge sys_clk);
        cpu_addr  = a;
        cpu_wdata = d;
        cpu_wr    = 1'b1;
        @(negedge sys_clk);
        cpu_wr    = 1'b0;
    endtask
    task automatic rd(string name, logic [15:0] a, logic [7:0] exp);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(negedge sys_clk);
        cpu_rd   = 1'b0;
        check(name, {24'h000000, cpu_rdata}, {24'h000000, exp});
    endtask
    task automatic wait_irq(bit on_a, int k, int bound);
        int s;
        s = on_a ? a_n : b_n;
        for (int i = 0; i < bound && (on_a ? a_n : b_n) < s + k; i++)
            @(negedge sys_clk);
        if ((on_a ? a_n : b_n) < s + k) begin
            check("irq_wait", on_a ? a_n : b_n, s + k);
            final_report();
        end
    endtask
    initial begin
        rstn      = 1'b0;
        cpu_wr    = 1'b0;
        cpu_rd    = 1'b0;
        cpu_addr  = 16'h0000;
        cpu_wdata = 8'h00;
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        // writes to a count and to an unmapped place are ignored
        wr(tmr_pkg::ADDR_CNT_B, 8'h55);
        wr(16'hff61, 8'h55);
        rd("cnt_a_rst", tmr_pkg::ADDR_CNT_A, 8'h00);
        rd("cnt_b_rst", tmr_pkg::ADDR_CNT_B, 8'h00);
        rd("mode_a_rst", tmr_pkg::ADDR_MODE_A, 8'h00);
        rd("mode_b_rst", tmr_pkg::ADDR_MODE_B, 8'h00);
        rd("unmapped", 16'hff61, 8'h00);
        // discrete b at full rate, square wave on the pin
        wr(tmr_pkg::ADDR_CMP_B_LO, 8'h02);
        wr(tmr_pkg::ADDR_MODE_B, 8'h81);
        wait_irq(1'b0, 3, 40);
        check("b_gap", b_gap, 3);
        check("sq_high", hi_w, 3);
        wr(tmr_pkg::ADDR_MODE_B, 8'h01);
        rd("b_stop", tmr_pkg::ADDR_CNT_B, 8'h00);
        // discrete a on the divide-by-64 tick
        wr(tmr_pkg::ADDR_CMP_A, 8'h01);
        wr(tmr_pkg::ADDR_MODE_A, 8'h80);
        wait_irq(1'b1, 2, 400);
        check("a_gap", a_gap, 128);
        wr(tmr_pkg::ADDR_MODE_A, 8'h00);
        rd("a_stop", tmr_pkg::ADDR_CNT_A, 8'h00);
        // pwm: channel a compare stays untouched and unused
        wr(tmr_pkg::ADDR_CMP_B_HI, 8'h04);
        wr(tmr_pkg::ADDR_MODE_B, 8'h85);
        wait_irq(1'b0, 4, 60);
        check("pwm_low", lo_w, 3);
        check("pwm_high", hi_w, 5);
        wr(tmr_pkg::ADDR_MODE_B, 8'h00);
        // carrier: burst gate timed by channel a pulses
        wr(tmr_pkg::ADDR_MODE_A, 8'h80);
        wr(tmr_pkg::ADDR_MODE_B, 8'h87);
        wait_irq(1'b1, 3, 500);
        repeat (4) @(negedge sys_clk);
        check("carrier_gate", a_gap, 128);
        check("carrier_off", lo_w >= 128 && lo_w <= 134, 1);
        wr(tmr_pkg::ADDR_MODE_B, 8'h00);
        // cascade with a run bit left clear: 16-bit compare 0102
        wr(tmr_pkg::ADDR_MODE_A, 8'h02);
        wr(tmr_pkg::ADDR_MODE_B, 8'h83);
        s_a = a_n;
        wait_irq(1'b0, 2, 700);
        check("casc_gap", b_gap, 259);
        check("casc_a_irq", a_n, s_a);
        check("casc_sq", hi_w, 259);
        repeat (300) @(negedge sys_clk);
        wr(tmr_pkg::ADDR_MODE_B, 8'h03);
        rd("casc_stop", tmr_pkg::ADDR_CNT_A, 8'h00);
        // prohibited mode code does not count; reserved bits masked
        wr(tmr_pkg::ADDR_MODE_A, 8'h00);
        wr(tmr_pkg::ADDR_MODE_B, 8'hc2);
        rd("mode_mask", tmr_pkg::ADDR_MODE_B, 8'h82);
        rd("bad_mode", tmr_pkg::ADDR_CNT_B, 8'h00);
        final_report();
    end
endmodule
`default_nettype wire
